//--- hdl/pcb_pin_config_bank.sv
// register bank and pin drivers for general-purpose pins 3, 5, 6, 7, 8
// assumes a synchronous register port; pin inputs and remote values arrive asynchronously
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns

module pcb_pin_config_bank
  import pcb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [DATA_W-1:0]   regRdData,
  input  wire logic                secondPortSelect,
  input  wire logic [NUM_PINS-1:0] remoteValue,
  input  wire logic [NUM_PINS-1:0] funcOut,
  input  wire logic [NUM_PINS-1:0] pinIn,
  output logic      [NUM_PINS-1:0] pinOut,
  output logic      [NUM_PINS-1:0] pinOe,
  input  wire logic                secondPortPin3In,
  output logic                     secondPortPin3Out,
  output logic                     secondPortPin3Oe,
  output logic      [NUM_PINS-1:0] pinInSync,
  output logic                     secondPortPin3InSync
);

  logic [7:0]            pin3Ctrl_q;
  logic [7:0]            pins56Ctrl_q;
  logic [7:0]            pins78Ctrl_q;
  logic [DATA_W-1:0]     rdData_d;
  logic [3:0]            nibble [NUM_PINS];
  logic [NUM_PINS-1:0]   outVal;
  logic [NUM_PINS-1:0]   outEn;
  logic [NUM_PINS:0]     syncIn;
  logic [NUM_PINS:0]     sync1_q;
  logic [NUM_PINS:0]     sync2_q;
  logic [NUM_PINS:0]     sync3_q;
  logic [NUM_PINS:0]     syncOut_q;
  logic [NUM_PINS-1:0]   remSync1_q;
  logic [NUM_PINS-1:0]   remSync2_q;
  logic [NUM_PINS-1:0]   remSync3_q;
  logic [NUM_PINS-1:0]   remVal_q;

  // whole byte stored, upper nibble of pin 3 included
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin3Ctrl_q   <= CTRL_RESET;
      pins56Ctrl_q <= CTRL_RESET;
      pins78Ctrl_q <= CTRL_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == PIN3_CTRL_ADDR)
        pin3Ctrl_q <= regWrData;
      if (regAddr == PINS56_CTRL_ADDR)
        pins56Ctrl_q <= regWrData;
      if (regAddr == PINS78_CTRL_ADDR)
        pins78Ctrl_q <= regWrData;
    end
  end

  always_comb
  begin
    unique case (regAddr)
      PIN3_CTRL_ADDR:   rdData_d = pin3Ctrl_q;
      PINS56_CTRL_ADDR: rdData_d = pins56Ctrl_q;
      PINS78_CTRL_ADDR: rdData_d = pins78Ctrl_q;
      default:          rdData_d = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      regRdData <= '0;
    else if (regRead)
      regRdData <= rdData_d;
    else
      regRdData <= '0;
  end

  // per-pin nibble view, pin order 3, 5, 6, 7, 8
  assign nibble[0] = pin3Ctrl_q[3:0];
  assign nibble[1] = pins56Ctrl_q[3:0];
  assign nibble[2] = pins56Ctrl_q[7:4];
  assign nibble[3] = pins78Ctrl_q[3:0];
  assign nibble[4] = pins78Ctrl_q[7:4];

  // remote values cross into clk through three stages
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      remSync1_q <= '0;
      remSync2_q <= '0;
      remSync3_q <= '0;
      remVal_q   <= '0;
    end
    else
    begin
      remSync1_q <= remoteValue;
      remSync2_q <= remSync1_q;
      remSync3_q <= remSync2_q;
      for (int i = 0; i < NUM_PINS; i++)
        if (remSync2_q[i] == remSync3_q[i])
          remVal_q[i] <= remSync3_q[i];
    end
  end

  // remote enable tested first so it outranks the local code
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : gPin
      always_comb
      begin
        if (nibble[g][FLD_REMOTE])
        begin
          outEn[g]  = 1'b1;
          outVal[g] = remVal_q[g];
        end
        else
        begin
          unique case ({nibble[g][FLD_DIR], nibble[g][FLD_EN]})
            MODE_FUNC_OUT:
            begin
              outEn[g]  = 1'b1;
              outVal[g] = funcOut[g];
            end
            MODE_GP_OUT:
            begin
              outEn[g]  = 1'b1;
              outVal[g] = nibble[g][FLD_VALUE];
            end
            MODE_TRISTATE:
            begin
              outEn[g]  = 1'b0;
              outVal[g] = 1'b0;
            end
            MODE_GP_IN:
            begin
              outEn[g]  = 1'b0;
              outVal[g] = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // pin 3 register steers either the first-port or second-port pin
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinOut            <= '0;
      pinOe             <= '0;
    end
    else
    begin
      pinOut[NUM_PINS-1:1] <= outVal[NUM_PINS-1:1];
      pinOe[NUM_PINS-1:1]  <= outEn[NUM_PINS-1:1];
      pinOut[0]            <= secondPortSelect ? 1'b0 : outVal[0];
      pinOe[0]             <= secondPortSelect ? 1'b0 : outEn[0];
    end
  end

  // second-port pin 3 follows the register only while selected
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      secondPortPin3Out <= 1'b0;
      secondPortPin3Oe  <= 1'b0;
    end
    else
    begin
      secondPortPin3Out <= secondPortSelect ? outVal[0] : 1'b0;
      secondPortPin3Oe  <= secondPortSelect ? outEn[0] : 1'b0;
    end
  end

  // pin levels synchronised for readback by other logic
  assign syncIn = {secondPortPin3In, pinIn};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      sync3_q   <= '0;
      syncOut_q <= '0;
    end
    else
    begin
      sync1_q <= syncIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i <= NUM_PINS; i++)
        if (sync2_q[i] == sync3_q[i])
          syncOut_q[i] <= sync3_q[i];
    end
  end

  assign pinInSync            = syncOut_q[NUM_PINS-1:0];
  assign secondPortPin3InSync = syncOut_q[NUM_PINS];

endmodule // pcb_pin_config_bank

//--- hdl/pcb_pkg.sv
// package for the general-purpose pin configuration bank (pins 3, 5, 6, 7, 8)
// assumes an 8-bit register port on the device clock
package pcb_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  PIN3_CTRL_ADDR  = 8'h1F;
  localparam logic [7:0]  PINS56_CTRL_ADDR = 8'h20;
  localparam logic [7:0]  PINS78_CTRL_ADDR = 8'h21;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  // field positions within one pin nibble
  localparam int          FLD_EN          = 0;
  localparam int          FLD_DIR         = 1;
  localparam int          FLD_REMOTE      = 2;
  localparam int          FLD_VALUE       = 3;
  // {dir, en} codes
  localparam logic [1:0]  MODE_FUNC_OUT   = 2'h0;
  localparam logic [1:0]  MODE_GP_OUT     = 2'h1;
  localparam logic [1:0]  MODE_TRISTATE   = 2'h2;
  localparam logic [1:0]  MODE_GP_IN      = 2'h3;
  // pin order in the per-pin vectors: 0=pin3, 1=pin5, 2=pin6, 3=pin7, 4=pin8
  localparam int          NUM_PINS        = 5;
  localparam int          SYNC_STAGES     = 3;
endpackage

//--- testbench/pcb_bank_assertions.sv
// port checks for the pin bank
// assumes one clock, bound below
`timescale 1ns/1ns
module pcb_bank_chk
  import pcb_pkg::*;
(
  input logic       clk,
  input logic       rst_n,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regRdData,
  input logic       secondPortSelect,
  input logic [4:0] pinOut,
  input logic [4:0] pinOe,
  input logic       secondPortPin3Oe
);
  wire wr56 = regWrite && regAddr == PINS56_CTRL_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WR_RD: assert property (wr56 ##1 regRead && $stable(regAddr)
    |=> regRdData == $past(regWrData, 2)) else $error("readback");
  AST_RD_NONE: assert property (regRead && regAddr > PINS78_CTRL_ADDR |=> !regRdData)
    else $error("unmapped read");
  AST_RESET: assert property (disable iff (1'h0) !rst_n |=> pinOe == 5'h00)
    else $error("reset drive");
  AST_SEL_ONE: assert property (secondPortSelect [*2] |-> !pinOe[0])
    else $error("first pin");
  AST_SEL_TWO: assert property (!secondPortSelect [*2] |-> !secondPortPin3Oe)
    else $error("second pin");
  AST_GP_OUT: assert property (wr56 && regWrData[2:0] == 3'h1 ##1 !regWrite
    |=> pinOe[1] && pinOut[1] == $past(regWrData[3], 2)) else $error("value");
  AST_TRI: assert property (wr56 && regWrData[6:5] == 2'h1 ##1 !regWrite |=> !pinOe[2])
    else $error("tristate");
  AST_REMOTE: assert property (wr56 && regWrData[6] ##1 !regWrite |=> pinOe[2])
    else $error("remote");
endmodule // pcb_bank_chk
bind pcb_pin_config_bank pcb_bank_chk u_chk (.*);

//--- testbench/pcb_far_model.sv
// far side: remote values and pad levels
// assumes a released pad shows the inverse
`timescale 1ns/1ns
module pcb_far_model
(
  input  logic       clk,
  input  logic [4:0] remoteSet,
  input  logic [4:0] pinOut,
  input  logic [4:0] pinOe,
  output logic [4:0] remoteValue,
  output logic [4:0] pinIn
);
  always_ff @(negedge clk) remoteValue <= remoteSet;
  assign pinIn = (pinOe & pinOut) | (~pinOe & ~pinOut);
endmodule // pcb_far_model

//--- testbench/pcb_pin_config_bank_test.sv
// bench for the pin bank: table rows, then edge cases
// assumes the bound checker and the far model
`timescale 1ns/1ns
module pcb_pin_config_bank_test
  import pcb_pkg::*;
;
  logic        clk = 1'h0, rst_n, regWrite, regRead, secondPortSelect, secondPortPin3In;
  logic        secondPortPin3Out, secondPortPin3Oe, secondPortPin3InSync;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [4:0]  funcOut = 5'h0A, remoteSet = 5'h15, remoteValue, pinIn, pinOut, pinOe, pinInSync;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  logic [25:0] rows [5] = '{{8'h20, 8'h29, 5'h1B, 5'h0A}, {8'h21, 8'h43, 5'h13, 5'h12},
    {8'h1F, 8'hF6, 5'h13, 5'h13}, {8'h20, 8'hE1, 5'h17, 5'h15}, {8'h21, 8'h80, 5'h1F, 5'h0D}};
  pcb_pin_config_bank u_dut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .regAddr              (regAddr),
    .regWrData            (regWrData),
    .regWrite             (regWrite),
    .regRead              (regRead),
    .regRdData            (regRdData),
    .secondPortSelect     (secondPortSelect),
    .remoteValue          (remoteValue),
    .funcOut              (funcOut),
    .pinIn                (pinIn),
    .pinOut               (pinOut),
    .pinOe                (pinOe),
    .secondPortPin3In     (secondPortPin3In),
    .secondPortPin3Out    (secondPortPin3Out),
    .secondPortPin3Oe     (secondPortPin3Oe),
    .pinInSync            (pinInSync),
    .secondPortPin3InSync (secondPortPin3InSync)
  );
  pcb_far_model u_far (
    .clk         (clk),
    .remoteSet   (remoteSet),
    .pinOut      (pinOut),
    .pinOe       (pinOe),
    .remoteValue (remoteValue),
    .pinIn       (pinIn)
  );
  always #25 clk = ~clk;
  always @(posedge clk)
    if (cyc++ == 2000) finish_test(1);
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    {regWrite, regRead, regAddr, regWrData} <= {w, r, a, d};
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
    if (g !== e) bad_count++;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    bus(1'h0, 1'h1, a, 8'h00);
    bus(1'h0, 1'h0, a, 8'h00);
    #1;
    chk("regRdData", e, regRdData);
  endtask
  task automatic finish_test(int t);
    if (bad_count + t == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {rst_n, regWrite, regRead, secondPortSelect, secondPortPin3In, regAddr, regWrData} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[i])
    begin
      bus(1'h1, 1'h0, rows[i][25:18], rows[i][17:10]);
      rd(rows[i][25:18], rows[i][17:10]);
      chk("pinOe", 8'(rows[i][9:5]), 8'(pinOe));
      chk("pinOut", 8'(rows[i][4:0]), 8'(pinOut & pinOe));
    end
    bus(1'h1, 1'h0, 8'h22, 8'hFF);
    rd(8'h22, 8'h00);
    @(posedge clk) secondPortSelect <= 1'h1;
    rd(8'h1F, 8'hF6);
    chk("pin3", 8'h03, 8'({pinOe[0], secondPortPin3Oe, secondPortPin3Out}));
    @(posedge clk) rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h20, 8'h00);
    chk("pinOe", 8'h1E, 8'(pinOe));
    @(posedge clk) secondPortPin3In <= 1'h1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("pinInSync", 8'(pinIn), 8'(pinInSync));
    chk("pin3InSync", 8'h01, 8'(secondPortPin3InSync));
    finish_test(0);
  end
endmodule // pcb_pin_config_bank_test
